// ### escg_pkg.sv
`default_nettype none
package escg_pkg;
  // ==========================================================
  // register map
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam logic [7:0] OFF_STATE = 8'h00;
  localparam logic [7:0] OFF_BMP_LO = 8'h04;
  localparam logic [7:0] OFF_BMP_HI = 8'h08;
  localparam logic [7:0] OFF_SUPPORT = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_LAST = 8'h18;
  // ==========================================================
  // state register fields
  localparam int ST_PE = 0;
  localparam int ST_PG = 1;
  localparam int ST_V86 = 2;
  localparam int ST_SMM = 3;
  localparam int ST_CPL_LO = 4;
  localparam int ST_CPL_HI = 5;
  localparam int ST_BASE_SUP = 6;
  localparam int ST_LOCK = 7;
  localparam int ST_ENABLE = 8;
  localparam int ST_LMA = 9;
  localparam int ST_CS_L = 10;
  localparam int ST_DS_EXPD = 11;
  localparam int ST_GUEST = 12;
  localparam int ST_EXIT_EN = 13;
  localparam int ST_W = 14;
  localparam logic [31:0] STATE_RST = 32'h0000_0000;
  localparam logic [31:0] BMP_RST = 32'h0000_0000;
  localparam logic [31:0] SUPPORT_RST = 32'h0000_FFFF;
  // ==========================================================
  // event bits, shared by status and mask
  localparam int EV_ABORT = 0;
  localparam int EV_UD = 1;
  localparam int EV_VMEXIT = 2;
  localparam int EV_GP = 3;
  localparam int EV_DISP = 4;
  localparam int EV_W = 5;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;
  // ==========================================================
  // last-result register fields
  localparam int LAST_KIND_LO = 0;
  localparam int LAST_LEAF_LO = 8;
  localparam int LAST_ADDR64 = 16;
  // ==========================================================
  // decode constants
  localparam logic [23:0] OPC_PRIV_CALL = 24'h0F01CF;
  localparam logic [1:0] CPL_TOP = 2'h0;
  localparam logic [31:0] EXIT_SPLIT = 32'h0000_003F;
  localparam int EXIT_TOP = 63;
  localparam logic [31:0] SUPPORT_LIMIT = 32'h0000_0020;
  localparam logic [31:0] GP_ERR_CODE = 32'h0000_0000;
  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_ABORT = 3'b001,
    K_UD = 3'b010,
    K_VMEXIT = 3'b011,
    K_GP = 3'b100,
    K_DISPATCH = 3'b101
  } escg_kind_t;
endpackage : escg_pkg
`default_nettype wire

// ### escg_gate.sv
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none
// Behaviour
// - decode opcode 0F 01 CF as privileged call
// - leaf index from accumulator, params pass through on dispatch only, zero otherwise
// - upper 32 accumulator bits never used
// - invalid opcode if unprotected, v86 or smm
// - invalid opcode unless privilege level zero
// - invalid opcode when base support flag clear
// - invalid opcode on lock/66/rep/vector prefixes
// - guest exit from bitmap bit of leaf, bit 63 for leaves 63 and above
// - exit check after opcode, before protection checks
// - protection fault code 0 if lock/enable clear
// - protection fault code 0 on unsupported leaf
// - protection fault when paging disabled
// - outside 64-bit, expand-down data segment faults
// - 64-bit width only with long mode and long cs
// - cs default size ignored, data segment based
// - segment, address-size and rex prefixes ignored
// - active transaction aborts before every check
module escg_gate #(
  parameter logic [31:0] SUPPORT_DEFAULT = escg_pkg::SUPPORT_RST
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [escg_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [escg_pkg::APB_DW-1:0] pwdata,
  output logic [escg_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire logic [23:0] op_bytes,
  input wire logic pfx_lock,
  input wire logic pfx_opsize,
  input wire logic pfx_rep,
  input wire logic pfx_vector_ext,
  input wire logic tsx_active,
  input wire logic [63:0] leaf_index_reg_wide,
  input wire logic [63:0] leaf_param_base,
  input wire logic [63:0] leaf_param_count,
  input wire logic [63:0] leaf_param_data,
  output logic res_valid,
  output escg_pkg::escg_kind_t res_kind,
  output logic [31:0] res_error_code,
  output logic [31:0] res_leaf,
  output logic [63:0] res_base,
  output logic [63:0] res_count,
  output logic [63:0] res_data,
  output logic res_addr64,
  output logic irq
);
  import escg_pkg::*;

  // ==========================================================
  // apb slave
  logic [31:0] state_reg;
  logic [31:0] bmp_lo_reg;
  logic [31:0] bmp_hi_reg;
  logic [31:0] support_reg;
  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] status_next;
  logic [EV_W-1:0] mask_reg;
  logic [31:0] prdata_reg;
  logic slverr_reg;
  logic rdy_reg;
  logic [31:0] rd_mux;
  logic rd_err;
  logic wr_go;
  logic rd_clr;
  logic [EV_W-1:0] events;
  logic res_valid_reg;
  escg_kind_t res_kind_reg;
  logic [31:0] res_err_reg;
  logic [31:0] res_leaf_reg;
  logic [63:0] res_base_reg;
  logic [63:0] res_count_reg;
  logic [63:0] res_data_reg;
  logic res_addr64_reg;

  assign pready = penable & rdy_reg & ce;
  assign prdata = prdata_reg;
  assign pslverr = slverr_reg & pready;
  assign wr_go = psel & pready & pwrite & ~slverr_reg;
  assign rd_clr = psel & pready & ~pwrite & (paddr == OFF_STATUS);

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      OFF_STATE: rd_mux = state_reg;
      OFF_BMP_LO: rd_mux = bmp_lo_reg;
      OFF_BMP_HI: rd_mux = bmp_hi_reg;
      OFF_SUPPORT: rd_mux = support_reg;
      OFF_STATUS: rd_mux[EV_W-1:0] = status_reg;
      OFF_MASK: rd_mux[EV_W-1:0] = mask_reg;
      OFF_LAST: begin
        rd_mux[LAST_KIND_LO +: 3] = res_kind_reg;
        rd_mux[LAST_LEAF_LO +: 8] = res_leaf_reg[7:0];
        rd_mux[LAST_ADDR64] = res_addr64_reg;
      end
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_reg <= 1'b0;
    end else if (ce) begin
      rdy_reg <= psel & ~(penable & rdy_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (ce && psel && !rdy_reg) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      slverr_reg <= rd_err;
    end
  end

  // ==========================================================
  // writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= STATE_RST;
      bmp_lo_reg <= BMP_RST;
      bmp_hi_reg <= BMP_RST;
      support_reg <= SUPPORT_DEFAULT;
      mask_reg <= MASK_RST;
    end else if (wr_go) begin
      case (paddr)
        OFF_STATE: state_reg <= {18'h00000, pwdata[ST_W-1:0]};
        OFF_BMP_LO: bmp_lo_reg <= pwdata;
        OFF_BMP_HI: bmp_hi_reg <= pwdata;
        OFF_SUPPORT: support_reg <= pwdata;
        OFF_MASK: mask_reg <= pwdata[EV_W-1:0];
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  // ==========================================================
  // sticky status, read clears only bits returned
  always_comb begin
    status_next = status_reg;
    if (rd_clr) begin
      status_next = status_reg & ~prdata_reg[EV_W-1:0];
    end
    status_next = status_next | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 5'h00;
    end else if (ce) begin
      status_reg <= status_next;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ==========================================================
  // check chain
  logic op_hit;
  logic in64;
  logic [31:0] leaf;
  logic [63:0] bitmap;
  logic exit_bit;
  logic leaf_ok;
  logic ud_cond;
  logic vm_cond;
  logic gp_cond;
  escg_kind_t kind_next;

  assign issue_ready = ce;
  assign op_hit = issue_valid & issue_ready & (op_bytes == OPC_PRIV_CALL);
  assign leaf = leaf_index_reg_wide[31:0];
  assign in64 = state_reg[ST_LMA] & state_reg[ST_CS_L];
  assign bitmap = {bmp_hi_reg, bmp_lo_reg};
  assign exit_bit = (leaf < EXIT_SPLIT) ? bitmap[leaf[5:0]] : bitmap[EXIT_TOP];
  assign leaf_ok = (leaf < SUPPORT_LIMIT) & support_reg[leaf[4:0]];

  assign ud_cond = ~state_reg[ST_PE] | state_reg[ST_V86] | state_reg[ST_SMM]
    | (state_reg[ST_CPL_HI:ST_CPL_LO] != CPL_TOP)
    | ~state_reg[ST_BASE_SUP]
    | pfx_lock | pfx_opsize | pfx_rep | pfx_vector_ext;

  assign vm_cond = state_reg[ST_GUEST] & state_reg[ST_EXIT_EN] & exit_bit;

  assign gp_cond = ~state_reg[ST_LOCK] | ~state_reg[ST_ENABLE]
    | ~leaf_ok
    | ~state_reg[ST_PG]
    | (~in64 & state_reg[ST_DS_EXPD]);

  always_comb begin
    kind_next = K_NONE;
    if (!op_hit) begin
      kind_next = K_NONE;
    end else if (tsx_active) begin
      kind_next = K_ABORT;
    end else if (ud_cond) begin
      kind_next = K_UD;
    end else if (vm_cond) begin
      kind_next = K_VMEXIT;
    end else if (gp_cond) begin
      kind_next = K_GP;
    end else begin
      kind_next = K_DISPATCH;
    end
  end

  always_comb begin
    events = 5'h00;
    case (kind_next)
      K_ABORT: events[EV_ABORT] = 1'b1;
      K_UD: events[EV_UD] = 1'b1;
      K_VMEXIT: events[EV_VMEXIT] = 1'b1;
      K_GP: events[EV_GP] = 1'b1;
      K_DISPATCH: events[EV_DISP] = 1'b1;
      default: events = 5'h00;
    endcase
  end

  // ==========================================================
  // result register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid_reg <= 1'b0;
    end else if (ce) begin
      res_valid_reg <= op_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_kind_reg <= K_NONE;
      res_err_reg <= GP_ERR_CODE;
      res_leaf_reg <= 32'h0000_0000;
      res_addr64_reg <= 1'b0;
    end else if (op_hit) begin
      res_kind_reg <= kind_next;
      res_err_reg <= GP_ERR_CODE;
      res_leaf_reg <= leaf;
      res_addr64_reg <= in64;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_base_reg <= 64'h0;
      res_count_reg <= 64'h0;
      res_data_reg <= 64'h0;
    end else if (op_hit) begin
      if (kind_next == K_DISPATCH) begin
        res_base_reg <= leaf_param_base;
        res_count_reg <= leaf_param_count;
        res_data_reg <= leaf_param_data;
      end else begin
        res_base_reg <= 64'h0;
        res_count_reg <= 64'h0;
        res_data_reg <= 64'h0;
      end
    end
  end

  assign res_valid = res_valid_reg;
  assign res_kind = res_kind_reg;
  assign res_error_code = res_err_reg;
  assign res_leaf = res_leaf_reg;
  assign res_base = res_base_reg;
  assign res_count = res_count_reg;
  assign res_data = res_data_reg;
  assign res_addr64 = res_addr64_reg;

  // ==========================================================
  // assertions
  AST_IGNORE_OTHER: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !op_hit) |=> !res_valid)
    else $error("result without matching opcode");

  AST_ABORT_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && tsx_active) |=> (res_valid && res_kind == K_ABORT))
    else $error("active transaction not aborted first");

  AST_UD_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && !tsx_active && (!state_reg[ST_PE] || state_reg[ST_V86] || state_reg[ST_SMM]))
    |=> res_kind == K_UD)
    else $error("mode fault missing");

  AST_UD_CPL: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && !tsx_active && state_reg[ST_CPL_HI:ST_CPL_LO] != 2'h0)
    |=> res_kind == K_UD)
    else $error("privilege fault missing");

  AST_UD_SUP: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && !tsx_active && !state_reg[ST_BASE_SUP]) |=> res_kind == K_UD)
    else $error("support flag fault missing");

  AST_UD_PFX: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && !tsx_active && (pfx_lock || pfx_opsize || pfx_rep || pfx_vector_ext))
    |=> res_kind == K_UD)
    else $error("prefix fault missing");

  AST_VM_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && !tsx_active && !ud_cond && state_reg[ST_GUEST] && state_reg[ST_EXIT_EN]
     && leaf > 32'd62 && bmp_hi_reg[31]) |=> res_kind == K_VMEXIT)
    else $error("high leaf exit missing");

  AST_VM_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    (res_valid && res_kind == K_GP) |-> !$past(vm_cond) && !$past(ud_cond))
    else $error("protection fault taken before exit check");

  AST_GP_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && !tsx_active && !ud_cond && !vm_cond && !state_reg[ST_LOCK])
    |=> (res_kind == K_GP && res_error_code == 32'h0))
    else $error("lock fault missing");

  AST_GP_PG: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && !tsx_active && !ud_cond && !vm_cond && !state_reg[ST_PG])
    |=> res_kind == K_GP)
    else $error("paging fault missing");

  AST_GP_EXPD: assert property (@(posedge pclk) disable iff (!presetn)
    (res_valid && res_kind == K_DISPATCH) |-> !(!res_addr64 && $past(state_reg[ST_DS_EXPD])))
    else $error("expand-down segment dispatched");

  AST_DISPATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (res_valid && res_kind == K_DISPATCH)
    |-> (res_leaf == $past(leaf_index_reg_wide[31:0]) && res_base == $past(leaf_param_base)))
    else $error("dispatch payload wrong");

  AST_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
    op_hit |=> res_addr64 == ($past(state_reg[ST_LMA]) && $past(state_reg[ST_CS_L])))
    else $error("address width wrong");

  AST_GP_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && !tsx_active && !ud_cond && !vm_cond && !state_reg[ST_ENABLE])
    |=> (res_kind == K_GP && res_error_code == 32'h0))
    else $error("enable fault missing");

  AST_GP_LEAF: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && !tsx_active && !ud_cond && !vm_cond
     && !(leaf_index_reg_wide[31:0] < SUPPORT_LIMIT && support_reg[leaf_index_reg_wide[4:0]]))
    |=> (res_kind == K_GP && res_error_code == 32'h0))
    else $error("unsupported leaf fault missing");

  AST_VM_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && !tsx_active && !ud_cond && state_reg[ST_GUEST] && state_reg[ST_EXIT_EN]
     && leaf_index_reg_wide[31:0] < EXIT_SPLIT && bitmap[leaf_index_reg_wide[5:0]])
    |=> res_kind == K_VMEXIT)
    else $error("bitmap exit missing");

  AST_VM_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && !(state_reg[ST_GUEST] && state_reg[ST_EXIT_EN])) |=> res_kind != K_VMEXIT)
    else $error("exit taken with exiting off");

  AST_LEAF_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    op_hit |=> res_leaf == $past(leaf_index_reg_wide[31:0]))
    else $error("leaf index not taken from low half");

  AST_PARAM_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (res_valid && res_kind != K_DISPATCH)
    |-> (res_base == 64'h0 && res_count == 64'h0 && res_data == 64'h0))
    else $error("parameters passed on a fault");

  AST_PARAM_REST: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && kind_next == K_DISPATCH)
    |=> (res_count == $past(leaf_param_count) && res_data == $past(leaf_param_data)))
    else $error("count or data parameter wrong");

  AST_PG_DISPATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (op_hit && kind_next == K_DISPATCH)
    |-> (state_reg[ST_PG] && state_reg[ST_LOCK] && state_reg[ST_ENABLE]))
    else $error("dispatch without paging, lock or enable");

endmodule : escg_gate
`default_nettype wire

// ### escg_issuer.sv
`default_nettype none
// ==========================================================
// issuing software model
module escg_issuer #(
  parameter logic [63:0] BASE_VAL = 64'h0,
  parameter logic [63:0] COUNT_VAL = 64'h0,
  parameter logic [63:0] DATA_VAL = 64'h0
) (
  input wire logic pclk,
  output logic issue_valid,
  output logic [23:0] op_bytes,
  output logic pfx_lock,
  output logic pfx_opsize,
  output logic pfx_rep,
  output logic pfx_vector_ext,
  output logic tsx_active,
  output logic [63:0] leaf_index_reg_wide,
  output logic [63:0] leaf_param_base,
  output logic [63:0] leaf_param_count,
  output logic [63:0] leaf_param_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    issue_valid = 1'b0;
    op_bytes = 24'h0;
    {pfx_lock, pfx_opsize, pfx_rep, pfx_vector_ext} = 4'h0;
    tsx_active = 1'b0;
    leaf_index_reg_wide = 64'h0;
    leaf_param_base = 64'h0;
    leaf_param_count = 64'h0;
    leaf_param_data = 64'h0;
  end
  // one-cycle offer, then opcode, leaf and params scrambled while idle, prefixes held
  task automatic issue(input logic [23:0] op, input logic [63:0] lf, input logic [3:0] pf,
                       input logic tx);
    @(posedge pclk);
    issue_valid <= 1'b1;
    op_bytes <= op;
    {pfx_lock, pfx_opsize, pfx_rep, pfx_vector_ext} <= pf;
    tsx_active <= tx;
    leaf_index_reg_wide <= lf;
    leaf_param_base <= BASE_VAL;
    leaf_param_count <= COUNT_VAL;
    leaf_param_data <= DATA_VAL;
    @(posedge pclk);
    issue_valid <= 1'b0;
    op_bytes <= ~op;
    tsx_active <= 1'b0;
    leaf_index_reg_wide <= ~lf;
    leaf_param_base <= ~BASE_VAL;
    leaf_param_count <= ~COUNT_VAL;
    leaf_param_data <= ~DATA_VAL;
  endtask : issue
endmodule : escg_issuer
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import escg_pkg::*;
  localparam logic [63:0] PB = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] PC = 64'hFEDC_BA98_7654_3210;
  localparam logic [63:0] PD = 64'h0F0F_1234_F0F0_5678;
  localparam logic [31:0] OK = (32'h1 << ST_PE) | (32'h1 << ST_PG) | (32'h1 << ST_BASE_SUP)
    | (32'h1 << ST_LOCK) | (32'h1 << ST_ENABLE) | (32'h1 << ST_LMA) | (32'h1 << ST_CS_L);
  localparam logic [31:0] GST = OK | (32'h1 << ST_GUEST) | (32'h1 << ST_EXIT_EN);
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic issue_valid, issue_ready, pfx_lock, pfx_opsize, pfx_rep, pfx_vector_ext;
  logic tsx_active, res_valid, res_addr64, irq;
  logic [7:0] paddr;
  logic [23:0] op_bytes;
  logic [31:0] pwdata, prdata, res_error_code, res_leaf, rd;
  logic [63:0] leaf_index_reg_wide, leaf_param_base, leaf_param_count, leaf_param_data;
  logic [63:0] res_base, res_count, res_data;
  escg_kind_t res_kind;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  escg_gate dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .issue_valid(issue_valid), .issue_ready(issue_ready),
    .op_bytes(op_bytes), .pfx_lock(pfx_lock), .pfx_opsize(pfx_opsize), .pfx_rep(pfx_rep),
    .pfx_vector_ext(pfx_vector_ext), .tsx_active(tsx_active),
    .leaf_index_reg_wide(leaf_index_reg_wide), .leaf_param_base(leaf_param_base),
    .leaf_param_count(leaf_param_count), .leaf_param_data(leaf_param_data),
    .res_valid(res_valid), .res_kind(res_kind), .res_error_code(res_error_code),
    .res_leaf(res_leaf), .res_base(res_base), .res_count(res_count), .res_data(res_data),
    .res_addr64(res_addr64), .irq(irq));
  escg_issuer #(.BASE_VAL(PB), .COUNT_VAL(PC), .DATA_VAL(PD)) sw (.pclk(pclk),
    .issue_valid(issue_valid), .op_bytes(op_bytes), .pfx_lock(pfx_lock),
    .pfx_opsize(pfx_opsize), .pfx_rep(pfx_rep), .pfx_vector_ext(pfx_vector_ext),
    .tsx_active(tsx_active), .leaf_index_reg_wide(leaf_index_reg_wide),
    .leaf_param_base(leaf_param_base), .leaf_param_count(leaf_param_count),
    .leaf_param_data(leaf_param_data));
  // ==========================================================
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ==========================================================
  // tasks
  function automatic logic [31:0] b(input int i);
    return 32'h1 << i;
  endfunction : b
  task automatic complete_run;
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [31:0] st, input logic [63:0] lf, input logic [3:0] pf,
                     input logic tx, input escg_kind_t k);
    apb(1'b1, OFF_STATE, st);
    sw.issue(OPC_PRIV_CALL, lf, pf, tx);
    #1;
    cmp(res_valid, 1'b1);
    cmp(res_kind, k);
    cmp(res_error_code, GP_ERR_CODE);
  endtask : run
  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_STATE, 32'h0);
    cmp(rd, STATE_RST);
    apb(1'b0, OFF_SUPPORT, 32'h0);
    cmp(rd, SUPPORT_RST);
    apb(1'b0, 8'h1C, 32'h0);
    cmp(err, 1'b1);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    cmp(err, 1'b1);
    apb(1'b1, OFF_STATE, 32'hFFFF_FFFF);
    apb(1'b0, OFF_STATE, 32'h0);
    cmp(rd, 32'h0000_3FFF);
    run(OK, 64'hFFFF_FFFF_0000_0005, 4'h0, 1'b0, K_DISPATCH);
    cmp(res_leaf, 32'h5);
    cmp(res_base, PB);
    cmp(res_count, PC);
    cmp(res_data, PD);
    cmp(res_addr64, 1'b1);
    apb(1'b0, OFF_LAST, 32'h0);
    cmp(rd, 32'h0001_0505);
    sw.issue(24'h0F01D7, 64'h5, 4'h0, 1'b0);
    #1;
    cmp(res_valid, 1'b0);
    run(OK & ~b(ST_CS_L), 64'h5, 4'h0, 1'b0, K_DISPATCH);
    cmp(res_addr64, 1'b0);
    run(OK & ~b(ST_PE), 64'h5, 4'h0, 1'b0, K_UD);
    run(OK | b(ST_V86), 64'h5, 4'h0, 1'b0, K_UD);
    run(OK | b(ST_SMM), 64'h5, 4'h0, 1'b0, K_UD);
    for (int i = 1; i < 4; i++) run(OK | (32'(i) << ST_CPL_LO), 64'h5, 4'h0, 1'b0, K_UD);
    run(OK & ~b(ST_BASE_SUP), 64'h5, 4'h0, 1'b0, K_UD);
    for (int i = 0; i < 4; i++) run(OK, 64'h5, 4'(4'h1 << i), 1'b0, K_UD);
    run(OK & ~b(ST_PE), 64'h5, 4'h0, 1'b1, K_ABORT);
    run(OK, 64'h5, 4'h0, 1'b1, K_ABORT);
    apb(1'b1, OFF_BMP_LO, 32'h0000_0020);
    apb(1'b1, OFF_BMP_HI, 32'h8000_0000);
    run(GST, 64'h5, 4'h0, 1'b0, K_VMEXIT);
    run(GST, 64'h6, 4'h0, 1'b0, K_DISPATCH);
    run(GST, 64'd63, 4'h0, 1'b0, K_VMEXIT);
    run(GST, 64'd200, 4'h0, 1'b0, K_VMEXIT);
    run(GST, 64'd62, 4'h0, 1'b0, K_GP);
    run(GST & ~b(ST_EXIT_EN), 64'h5, 4'h0, 1'b0, K_DISPATCH);
    run(GST & ~b(ST_LOCK), 64'h5, 4'h0, 1'b0, K_VMEXIT);
    run(GST | b(ST_CPL_LO), 64'h5, 4'h0, 1'b0, K_UD);
    run(OK & ~b(ST_LOCK), 64'h5, 4'h0, 1'b0, K_GP);
    run(OK & ~b(ST_ENABLE), 64'h5, 4'h0, 1'b0, K_GP);
    run(OK, 64'd16, 4'h0, 1'b0, K_GP);
    run(OK, 64'd15, 4'h0, 1'b0, K_DISPATCH);
    run(OK & ~b(ST_LMA) | b(ST_DS_EXPD), 64'h5, 4'h0, 1'b0, K_GP);
    run(OK | b(ST_DS_EXPD), 64'h5, 4'h0, 1'b0, K_DISPATCH);
    @(posedge pclk);
    ce <= 1'b0;
    sw.issue(OPC_PRIV_CALL, 64'h5, 4'h0, 1'b0);
    #1;
    cmp(res_valid, 1'b0);
    cmp(issue_ready, 1'b0);
    @(posedge pclk);
    ce <= 1'b1;
    cmp(irq, 1'b0);
    apb(1'b0, OFF_STATUS, 32'h0);
    apb(1'b1, OFF_MASK, b(EV_DISP));
    run(OK, 64'h5, 4'h0, 1'b0, K_DISPATCH);
    cmp(irq, 1'b1);
    run(OK & ~b(ST_PG), 64'h5, 4'h0, 1'b0, K_GP);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd, b(EV_DISP) | b(EV_GP));
    #1;
    cmp(irq, 1'b0);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd, 32'h0);
    complete_run();
  end
endmodule : tb
`default_nettype wire
